// *** pdmc_pkg.sv ***
// Package for the power-down mode controller: constants, modes and control struct
package pdmc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] PDMC_IDX_CTRL_ONE = 16'hFFF0;
  localparam logic [15:0] PDMC_IDX_CTRL_TWO = 16'hFFF1;
  localparam logic [15:0] PDMC_IDX_STATUS = 16'hFFF2;

  // system_control_one fields
  localparam int PDMC_C1_STANDBY = 7;
  localparam int PDMC_C1_WAIT_HI = 6;
  localparam int PDMC_C1_WAIT_LO = 4;
  localparam int PDMC_C1_LOW_SPEED = 3;
  localparam int PDMC_C1_SPARE = 2;
  localparam logic [7:0] PDMC_C1_RESET = 8'h00;

  // system_control_two fields
  localparam int PDMC_C2_DIRECT = 3;
  localparam logic [7:0] PDMC_C2_RESET = 8'hF4;
  localparam logic [7:0] PDMC_C2_FIXED_ONES = 8'hF4;

  // Shortest stabilisation wait in system-clock states
  localparam int PDMC_WAIT_BASE = 8192;
  localparam int PDMC_CNT_W = 18;
  localparam logic [2:0] PDMC_WAIT_MAX_SHIFT = 3'h4;

  // Subclock tick divider from the system clock
  localparam int PDMC_SUB_DIV = 8;
  localparam logic [3:0] PDMC_SUB_DIV_LAST = 4'(PDMC_SUB_DIV - 1);

  typedef enum logic [2:0] {
    M_ACTIVE,
    M_STANDBY,
    M_WATCH,
    M_SUBACTIVE,
    M_WAIT,
    M_RESET_HOLD
  } pdmc_mode_e;

  typedef struct packed {
    logic sysclk_run;
    logic cpu_clk_run;
    logic cpu_on_subclk;
    logic periph_run;
    logic periph_out_reset;
    logic port_hiz;
    logic hv_pmos_off;
    logic timer_a_timebase;
    logic cpu_reset;
  } pdmc_ctrl_s;

endpackage

// *** pdmc_wait_counter.sv ***
// Stabilisation wait counter for the power-down mode controller
`timescale 1ns/1ns
module pdmc_wait_counter
  import pdmc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Control
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic [PDMC_CNT_W-1:0] i_length,
  // Result
  output logic o_done
);

  logic [PDMC_CNT_W-1:0] count_reg;
  logic [PDMC_CNT_W-1:0] last_reg;
  logic run_reg;

  always_ff @(posedge i_clk) begin
    if (i_reset || i_abort) begin
      run_reg <= 1'b0;
      count_reg <= '0;
      last_reg <= '0;
    end else if (i_start) begin
      run_reg <= 1'b1;
      count_reg <= '0;
      last_reg <= i_length - PDMC_CNT_W'(1);
    end else if (run_reg) begin
      count_reg <= count_reg + PDMC_CNT_W'(1);
      if (count_reg == last_reg) begin
        run_reg <= 1'b0;
      end
    end
  end

  assign o_done = run_reg && (count_reg == last_reg) && !i_abort;

endmodule

// *** pdmc_top.sv ***
// Power-down mode controller: mode sequencer with Avalon-MM control registers
`timescale 1ns/1ns
module pdmc_top
  import pdmc_pkg::*;
#(
  parameter int WAIT_BASE = PDMC_WAIT_BASE
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Avalon-MM slave
  input wire logic [17:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // CPU and interrupt logic
  input wire logic i_sleep,
  input wire logic i_watch_select,
  input wire logic i_irq_mask_bit,
  input wire logic i_ie_irq_zero,
  input wire logic i_ie_irq_one,
  input wire logic i_ie_timer_a,
  input wire logic i_ie_direct,
  input wire logic i_timer_a_ovf,
  // Pins
  input wire logic i_ext_irq_zero,
  input wire logic i_ext_irq_one,
  input wire logic i_reset_pin_n,
  // Mode outputs
  output pdmc_ctrl_s o_ctrl,
  output pdmc_mode_e o_mode,
  output logic o_subclk_tick,
  output logic o_irq_exc,
  output logic o_reset_exc
);

  logic [1:0] ext_irq_zero_sync_reg;
  logic [1:0] ext_irq_one_sync_reg;
  logic [1:0] rst_sync_reg;
  pdmc_mode_e mode_reg;
  pdmc_mode_e mode_next;
  pdmc_ctrl_s ctrl_reg;
  logic [7:0] ctrl_one_reg;
  logic [7:0] ctrl_two_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic irq_exc_reg;
  logic rst_exc_reg;
  logic [3:0] sub_cnt_reg;
  logic sub_tick_reg;
  logic wait_start;
  logic wait_done;
  logic [PDMC_CNT_W-1:0] wait_len;
  logic [2:0] wait_shift;
  logic pin_low;
  logic ext_irq_zero_ok;
  logic ext_irq_one_ok;
  logic tmr_ok;
  logic direct_ok;
  logic low_speed;
  logic low_power;
  logic bus_req;
  logic sel_one;
  logic sel_two;
  logic sel_stat;

  // Pins cross into the clock domain
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ext_irq_zero_sync_reg <= 2'h0;
      ext_irq_one_sync_reg <= 2'h0;
      rst_sync_reg <= 2'h3;
    end else begin
      ext_irq_zero_sync_reg <= {ext_irq_zero_sync_reg[0], i_ext_irq_zero};
      ext_irq_one_sync_reg <= {ext_irq_one_sync_reg[0], i_ext_irq_one};
      rst_sync_reg <= {rst_sync_reg[0], i_reset_pin_n};
    end
  end

  assign pin_low = !rst_sync_reg[1];
  assign low_speed = ctrl_one_reg[PDMC_C1_LOW_SPEED];
  assign ext_irq_zero_ok = ext_irq_zero_sync_reg[1] && i_ie_irq_zero && !i_irq_mask_bit;
  assign ext_irq_one_ok = ext_irq_one_sync_reg[1] && i_ie_irq_one && !i_irq_mask_bit;
  assign tmr_ok = i_timer_a_ovf && i_ie_timer_a && !i_irq_mask_bit;
  assign direct_ok = i_ie_direct && !i_irq_mask_bit && !low_speed;
  assign low_power = (mode_reg != M_ACTIVE) && (mode_reg != M_RESET_HOLD);

  assign wait_shift = ctrl_one_reg[PDMC_C1_WAIT_HI] ? PDMC_WAIT_MAX_SHIFT :
                      {1'b0, ctrl_one_reg[PDMC_C1_WAIT_LO+1:PDMC_C1_WAIT_LO]};
  assign wait_len = PDMC_CNT_W'(WAIT_BASE) << wait_shift;

  always_comb begin
    mode_next = mode_reg;
    wait_start = 1'b0;
    if (pin_low) begin
      mode_next = M_RESET_HOLD;
    end else begin
      case (mode_reg)
        M_ACTIVE: begin
          if (i_sleep && ctrl_one_reg[PDMC_C1_STANDBY]) begin
            mode_next = i_watch_select ? M_WATCH : M_STANDBY;
          end
        end
        M_STANDBY: begin
          if (ext_irq_zero_ok || ext_irq_one_ok) begin
            mode_next = M_WAIT;
            wait_start = 1'b1;
          end
        end
        M_WATCH: begin
          // wake by timer or irq zero
          if (tmr_ok || ext_irq_zero_ok) begin
            mode_next = low_speed ? M_SUBACTIVE : M_WAIT;
            wait_start = !low_speed;
          end
        end
        M_SUBACTIVE: begin
          if (i_sleep) begin
            if (ctrl_two_reg[PDMC_C2_DIRECT] && direct_ok) begin
              mode_next = M_WAIT;
              wait_start = 1'b1;
            end else begin
              mode_next = M_WATCH;
            end
          end
        end
        M_WAIT: begin
          if (wait_done) begin
            mode_next = M_ACTIVE;
          end
        end
        M_RESET_HOLD: begin
          mode_next = M_ACTIVE;
        end
        default: begin
          mode_next = M_ACTIVE;
        end
      endcase
    end
  end

  function automatic pdmc_ctrl_s decode(input pdmc_mode_e m);
    pdmc_ctrl_s c;
    c = '0;
    case (m)
      M_ACTIVE: begin
        c.sysclk_run = 1'b1;
        c.cpu_clk_run = 1'b1;
        c.periph_run = 1'b1;
      end
      M_STANDBY: begin
        c.periph_out_reset = 1'b1;
        c.port_hiz = 1'b1;
        c.hv_pmos_off = 1'b1;
      end
      M_WATCH: begin
        c.periph_out_reset = 1'b1;
        c.port_hiz = 1'b1;
        c.hv_pmos_off = 1'b1;
        c.timer_a_timebase = 1'b1;
      end
      M_SUBACTIVE: begin
        c.cpu_clk_run = 1'b1;
        c.cpu_on_subclk = 1'b1;
        c.periph_out_reset = 1'b1;
        c.port_hiz = 1'b1;
        c.hv_pmos_off = 1'b1;
        c.timer_a_timebase = 1'b1;
      end
      M_WAIT: begin
        // Generator runs, clock withheld until stable
        c.sysclk_run = 1'b1;
        c.periph_out_reset = 1'b1;
        c.port_hiz = 1'b1;
        c.hv_pmos_off = 1'b1;
      end
      M_RESET_HOLD: begin
        c.sysclk_run = 1'b1;
        c.cpu_clk_run = 1'b1;
        c.cpu_reset = 1'b1;
      end
      default: begin
        c.cpu_reset = 1'b1;
      end
    endcase
    return c;
  endfunction

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      mode_reg <= M_ACTIVE;
      ctrl_reg <= decode(M_ACTIVE);
    end else begin
      mode_reg <= mode_next;
      ctrl_reg <= decode(mode_next);
    end
  end

  // Exception start pulses
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      irq_exc_reg <= 1'b0;
      rst_exc_reg <= 1'b0;
    end else begin
      irq_exc_reg <= (mode_reg == M_WAIT) && (mode_next == M_ACTIVE);
      rst_exc_reg <= (mode_reg == M_RESET_HOLD) && (mode_next == M_ACTIVE);
    end
  end

  pdmc_wait_counter u_wait (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_start(wait_start),
    .i_abort(pin_low),
    .i_length(wait_len),
    .o_done(wait_done)
  );

  always_ff @(posedge i_clk) begin
    if (i_reset || !ctrl_reg.timer_a_timebase) begin
      sub_cnt_reg <= 4'h0;
      sub_tick_reg <= 1'b0;
    end else begin
      sub_tick_reg <= (sub_cnt_reg == PDMC_SUB_DIV_LAST);
      sub_cnt_reg <= (sub_cnt_reg == PDMC_SUB_DIV_LAST) ? 4'h0 : sub_cnt_reg + 4'h1;
    end
  end

  // Bus answers one cycle after the request appears
  assign bus_req = i_avs_read || i_avs_write;
  assign o_avs_waitrequest = bus_req && !ack_reg;
  assign sel_one = i_avs_address[17:2] == PDMC_IDX_CTRL_ONE;
  assign sel_two = i_avs_address[17:2] == PDMC_IDX_CTRL_TWO;
  assign sel_stat = i_avs_address[17:2] == PDMC_IDX_STATUS;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_req && !ack_reg;
      if (i_avs_read && !ack_reg) begin
        rdata_reg <= 32'h0000_0000;
        if (sel_one) begin
          rdata_reg[7:0] <= {ctrl_one_reg[7:2], 2'h0};
        end else if (sel_two) begin
          rdata_reg[7:0] <= ctrl_two_reg;
        end else if (sel_stat) begin
          rdata_reg[2:0] <= mode_reg;
        end
      end
    end
  end

  // Standby and direct bit writes are gated by the current mode
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctrl_one_reg <= PDMC_C1_RESET;
      ctrl_two_reg <= PDMC_C2_RESET;
    end else if (i_avs_write && ack_reg && i_avs_byteenable[0]) begin
      if (sel_one) begin
        ctrl_one_reg[6:2] <= i_avs_writedata[6:2];
        // standby select cleared only by software
        if (mode_reg == M_ACTIVE) begin
          ctrl_one_reg[PDMC_C1_STANDBY] <= i_avs_writedata[PDMC_C1_STANDBY];
        end
      end
      if (sel_two) begin
        ctrl_two_reg[1:0] <= i_avs_writedata[1:0];
        if (mode_reg == M_SUBACTIVE) begin
          ctrl_two_reg[PDMC_C2_DIRECT] <= i_avs_writedata[PDMC_C2_DIRECT];
        end
      end
    end
  end

  assign o_avs_readdata = rdata_reg;
  assign o_ctrl = ctrl_reg;
  assign o_mode = mode_reg;
  assign o_subclk_tick = sub_tick_reg;
  assign o_irq_exc = irq_exc_reg;
  assign o_reset_exc = rst_exc_reg;

  // Helper: cycles spent in the wait state
  logic [PDMC_CNT_W:0] h_wait_cnt;
  logic [PDMC_CNT_W-1:0] h_wait_len;
  always_ff @(posedge i_clk) begin
    if (i_reset || mode_reg != M_WAIT) begin
      h_wait_cnt <= '0;
    end else begin
      h_wait_cnt <= h_wait_cnt + (PDMC_CNT_W+1)'(1);
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      h_wait_len <= '0;
    end else if (wait_start) begin
      h_wait_len <= wait_len;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_sleep_standby_select;
    mode_reg == M_ACTIVE && i_sleep && ctrl_one_reg[PDMC_C1_STANDBY] && !pin_low;
  endsequence
  sequence s_wait_done;
    mode_reg == M_WAIT ##1 mode_reg == M_ACTIVE;
  endsequence
  sequence s_reset_release;
    mode_reg == M_RESET_HOLD && !pin_low;
  endsequence

  a_standby_entry: assert property (s_sleep_standby_select ##0 !i_watch_select |=> mode_reg == M_STANDBY)
    else $error("standby not entered");
  a_watch_entry: assert property (s_sleep_standby_select ##0 i_watch_select |=> mode_reg == M_WATCH)
    else $error("watch not entered");
  a_standby_ports: assert property (mode_reg == M_STANDBY |-> o_ctrl.port_hiz &&
    o_ctrl.hv_pmos_off && !o_ctrl.sysclk_run && !o_ctrl.cpu_clk_run)
    else $error("standby outputs wrong");
  a_masked_hold: assert property ((mode_reg == M_STANDBY || mode_reg == M_WATCH) &&
    i_irq_mask_bit && !pin_low |=> mode_reg == $past(mode_reg))
    else $error("masked interrupt left low-power mode");
  a_wait_length: assert property (s_wait_done |-> h_wait_cnt ==
    (PDMC_CNT_W+1)'(h_wait_len) && o_irq_exc)
    else $error("wait length wrong");
  a_low_speed_select_subactive: assert property (mode_reg == M_WATCH && low_speed && tmr_ok && !pin_low
    |=> mode_reg == M_SUBACTIVE ##0 o_ctrl.cpu_on_subclk)
    else $error("no subactive entry");
  a_watch_wake: assert property (mode_reg == M_WATCH && !low_speed && ext_irq_zero_ok && !pin_low
    |=> mode_reg == M_WAIT ##0 o_ctrl.sysclk_run && !o_ctrl.cpu_clk_run)
    else $error("watch wake not started");
  a_reset_exit: assert property (low_power && pin_low |=> mode_reg == M_RESET_HOLD &&
    o_ctrl.sysclk_run && o_ctrl.cpu_reset)
    else $error("reset pin did not end mode");
  a_reset_release: assert property (s_reset_release |=> mode_reg == M_ACTIVE ##0
    o_reset_exc)
    else $error("reset release sequence wrong");
  a_standby_select_kept: assert property (s_wait_done |-> ctrl_one_reg[PDMC_C1_STANDBY] ==
    $past(ctrl_one_reg[PDMC_C1_STANDBY], 2))
    else $error("standby select changed on wake");
  a_direct_block: assert property (mode_reg == M_SUBACTIVE && i_sleep && !pin_low &&
    (i_irq_mask_bit || low_speed || !ctrl_two_reg[PDMC_C2_DIRECT]) |=> mode_reg == M_WATCH)
    else $error("subactive sleep did not go to watch");
  a_sub_clock: assert property (mode_reg == M_SUBACTIVE |-> o_ctrl.cpu_on_subclk &&
    !o_ctrl.periph_run && o_ctrl.port_hiz)
    else $error("subactive outputs wrong");
  a_bus_answer: assert property (bus_req && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus answer late");

endmodule

// *** pdmc_far_side.sv ***
// Far-side model: CPU sleep strobe, interrupt logic and reset pin
`timescale 1ns/1ns
module pdmc_far_side #(
  parameter int HOLD = 80
) (
  // Clock
  input wire logic i_clk,
  // CPU and interrupt logic
  output logic o_sleep,
  output logic o_watch_select,
  output logic o_irq_mask_bit,
  output logic o_ie_irq_zero,
  output logic o_ie_irq_one,
  output logic o_ie_timer_a,
  output logic o_ie_direct,
  output logic o_timer_a_ovf,
  // Pins
  output logic o_ext_irq_zero,
  output logic o_ext_irq_one,
  output logic o_reset_pin_n
);
  // Idle levels before the first clock edge
  initial begin
    o_sleep = 1'h0;
    o_watch_select = 1'h0;
    o_irq_mask_bit = 1'h0;
    o_ie_irq_zero = 1'h0;
    o_ie_irq_one = 1'h0;
    o_ie_timer_a = 1'h0;
    o_ie_direct = 1'h0;
    o_timer_a_ovf = 1'h0;
    o_ext_irq_zero = 1'h0;
    o_ext_irq_one = 1'h0;
    o_reset_pin_n = 1'h1;
  end

  // Enables order: zero, one, timer, direct
  task automatic sleep_now(input logic wsel, input logic [3:0] ie);
    @(posedge i_clk);
    {o_ie_irq_zero, o_ie_irq_one, o_ie_timer_a, o_ie_direct} <= ie;
    o_watch_select <= wsel;
    o_sleep <= 1'h1;
    @(posedge i_clk);
    o_sleep <= 1'h0;
  endtask

  // Sources order: pin zero, pin one, timer
  task automatic pulse(input logic [2:0] src);
    @(posedge i_clk);
    {o_ext_irq_zero, o_ext_irq_one, o_timer_a_ovf} <= src;
    @(posedge i_clk);
    {o_ext_irq_zero, o_ext_irq_one, o_timer_a_ovf} <= 3'h0;
  endtask

  task automatic set_mask(input logic m);
    @(posedge i_clk);
    o_irq_mask_bit <= m;
  endtask

  task automatic reset_low();
    @(posedge i_clk);
    o_reset_pin_n <= 1'h0;
    repeat (HOLD) @(posedge i_clk);
  endtask

  task automatic reset_release();
    @(posedge i_clk);
    o_reset_pin_n <= 1'h1;
  endtask
endmodule

// *** testbench.sv ***
// Self-checking testbench for the power-down mode controller
`timescale 1ns/1ns
module testbench
  import pdmc_pkg::*;
;
  localparam int WB = 4;
  localparam logic [17:0] A1 = 18'h3FFC0;
  localparam logic [17:0] A2 = 18'h3FFC4;
  localparam logic [17:0] A3 = 18'h3FFC8;
  logic i_clk = 1'h0;
  logic i_reset = 1'h1;
  logic [17:0] avs_address = 18'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic sleep, watch_select, mask_bit, ie_zero, ie_one, ie_timer, ie_direct;
  logic timer_ovf, pin_zero, pin_one, reset_pin_n;
  pdmc_ctrl_s o_ctrl;
  pdmc_mode_e o_mode;
  logic o_subclk_tick, o_irq_exc, o_reset_exc;
  int num_errors = 0;
  int checked = 0;
  logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};

  always #25 i_clk = ~i_clk;

  pdmc_far_side #(.HOLD(80)) far (
    .i_clk(i_clk), .o_sleep(sleep), .o_watch_select(watch_select),
    .o_irq_mask_bit(mask_bit), .o_ie_irq_zero(ie_zero), .o_ie_irq_one(ie_one),
    .o_ie_timer_a(ie_timer), .o_ie_direct(ie_direct), .o_timer_a_ovf(timer_ovf),
    .o_ext_irq_zero(pin_zero), .o_ext_irq_one(pin_one), .o_reset_pin_n(reset_pin_n));

  pdmc_top #(.WAIT_BASE(WB)) uut (
    .i_clk(i_clk), .i_reset(i_reset), .i_avs_address(avs_address),
    .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
    .i_avs_byteenable(avs_byteenable), .o_avs_readdata(avs_readdata),
    .o_avs_waitrequest(avs_waitrequest), .i_sleep(sleep), .i_watch_select(watch_select),
    .i_irq_mask_bit(mask_bit), .i_ie_irq_zero(ie_zero), .i_ie_irq_one(ie_one),
    .i_ie_timer_a(ie_timer), .i_ie_direct(ie_direct), .i_timer_a_ovf(timer_ovf),
    .i_ext_irq_zero(pin_zero), .i_ext_irq_one(pin_one), .i_reset_pin_n(reset_pin_n),
    .o_ctrl(o_ctrl), .o_mode(o_mode), .o_subclk_tick(o_subclk_tick),
    .o_irq_exc(o_irq_exc), .o_reset_exc(o_reset_exc));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("Counts: %0d checks, %0d mismatches", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [17:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    @(posedge i_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= ~wr;
    // Settled level that the coming rising edge samples
    do @(negedge i_clk); while (avs_waitrequest !== 1'h0);
    @(posedge i_clk);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask

  task automatic go(input pdmc_mode_e m);
    int n;
    n = 0;
    // Registered outputs are read mid-cycle, away from the launching edge
    do begin
      @(negedge i_clk);
      n++;
    end while (o_mode !== m && n < 8);
    chk("mode", 32'(o_mode), 32'(m));
  endtask

  // Counts the cycles spent waiting, then looks for the exception pulse
  task automatic wake(input int len);
    int n;
    go(M_WAIT);
    n = 0;
    while (o_mode === M_WAIT && n < 300) begin
      @(negedge i_clk);
      n++;
    end
    chk("wait_len", 32'(n), 32'(len));
    n = 0;
    while (o_irq_exc !== 1'h1 && n < 3) begin
      @(negedge i_clk);
      n++;
    end
    chk("irq_exc", 32'(o_irq_exc), 32'h1);
  endtask

  task automatic to_sub();
    logic [31:0] q;
    bus(1'h1, A1, 8'h98, q);
    far.sleep_now(1'h1, 4'hB);
    go(M_WATCH);
    // Timer A wake here; the later round trips use the zero pin
    far.pulse(3'h1);
    go(M_SUBACTIVE);
  endtask

  initial begin
    logic [31:0] q;
    int ticks;
    repeat (3) @(posedge i_clk);
    i_reset <= 1'h0;
    bus(1'h0, A1, 8'h0, q);
    chk("ctrl_one", q, 32'h0);
    bus(1'h0, A2, 8'h0, q);
    chk("ctrl_two", q, 32'hF4);
    // Direct bit locked outside subactive, fixed bits stay
    bus(1'h1, A2, 8'h0B, q);
    bus(1'h0, A2, 8'h0, q);
    chk("ctrl_two", q, 32'hF7);
    bus(1'h1, A1, 8'hFF, q);
    bus(1'h0, A1, 8'h0, q);
    chk("ctrl_one", q, 32'hFC);
    // Lane zero off: the write must not land
    avs_byteenable <= 4'hE;
    bus(1'h1, A1, 8'h00, q);
    avs_byteenable <= 4'hF;
    bus(1'h0, A1, 8'h0, q);
    chk("lane_off", q, 32'hFC);
    bus(1'h0, 18'h00010, 8'h0, q);
    chk("unmapped", q, 32'h0);
    $display("test registers done");
    foreach (codes[i]) begin
      bus(1'h1, A1, {1'h1, codes[i], 4'h0}, q);
      far.sleep_now(1'h0, 4'hC);
      go(M_STANDBY);
      chk("stby_ctrl", 32'({o_ctrl.sysclk_run, o_ctrl.cpu_clk_run, o_ctrl.port_hiz,
          o_ctrl.hv_pmos_off}), 32'h3);
      if (i == 0) begin
        far.set_mask(1'h1);
        far.pulse(3'h2);
        repeat (8) @(negedge i_clk);
        chk("masked", 32'(o_mode), 32'(M_STANDBY));
        far.set_mask(1'h0);
      end
      far.pulse(i[0] ? 3'h4 : 3'h2);
      wake(WB << ((codes[i] > 3'h3) ? 4 : codes[i]));
      bus(1'h0, A1, 8'h0, q);
      chk("standby_kept", 32'(q[7]), 32'h1);
    end
    $display("test standby done");
    bus(1'h1, A1, 8'h90, q);
    far.sleep_now(1'h1, 4'h2);
    go(M_WATCH);
    chk("watch_ctrl", 32'({o_ctrl.sysclk_run, o_ctrl.timer_a_timebase,
        o_ctrl.periph_out_reset, o_ctrl.periph_run}), 32'h6);
    ticks = 0;
    repeat (16) begin
      @(negedge i_clk);
      if (o_subclk_tick === 1'h1) ticks++;
    end
    chk("ticks", 32'(ticks), 32'h2);
    far.pulse(3'h1);
    wake(2 * WB);
    $display("test watch done");
    to_sub();
    chk("sub_ctrl", 32'({o_ctrl.cpu_on_subclk, o_ctrl.cpu_clk_run, o_ctrl.port_hiz}),
        32'h7);
    bus(1'h0, A3, 8'h0, q);
    chk("status", q, 32'(M_SUBACTIVE));
    bus(1'h1, A2, 8'hF4, q);
    far.sleep_now(1'h0, 4'h9);
    go(M_WATCH);
    far.pulse(3'h4);
    go(M_SUBACTIVE);
    bus(1'h1, A2, 8'hFC, q);
    far.sleep_now(1'h0, 4'h9);
    go(M_WATCH);
    far.pulse(3'h4);
    go(M_SUBACTIVE);
    bus(1'h1, A1, 8'h90, q);
    far.set_mask(1'h1);
    far.sleep_now(1'h0, 4'h9);
    go(M_WATCH);
    far.set_mask(1'h0);
    far.pulse(3'h4);
    wake(2 * WB);
    to_sub();
    bus(1'h1, A1, 8'h90, q);
    far.sleep_now(1'h0, 4'h1);
    wake(2 * WB);
    $display("test subactive done");
    to_sub();
    far.reset_low();
    go(M_RESET_HOLD);
    far.reset_release();
    go(M_ACTIVE);
    ticks = 0;
    while (o_reset_exc !== 1'h1 && ticks < 4) begin
      @(negedge i_clk);
      ticks++;
    end
    chk("reset_exc", 32'(o_reset_exc), 32'h1);
    $display("test reset pin done");
    results();
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    num_errors++;
    results();
  end
endmodule
